//--- src/trigger_seq_pkg.sv
package trigger_seq_pkg;

  localparam int unsigned CLOCK_HZ   = 25_000_000;
  localparam int unsigned QUEUE_LEN  = 8;
  localparam int unsigned IN_COUNT   = 16;
  localparam int unsigned OUT_COUNT  = 32;
  localparam int unsigned INT_COUNT  = 4;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TLIM0  = 8'h08;
  localparam logic [7:0] ADDR_TLIM1  = 8'h0c;
  localparam logic [7:0] ADDR_CLIM0  = 8'h10;
  localparam logic [7:0] ADDR_CLIM1  = 8'h14;
  localparam logic [7:0] ADDR_SDLIM  = 8'h18;
  localparam logic [7:0] ADDR_LIT    = 8'h1c;
  localparam logic [7:0] ADDR_HOLD   = 8'h20;
  localparam logic [7:0] ADDR_WDLIM  = 8'h24;
  localparam logic [7:0] ADDR_ISTAT  = 8'h28;
  localparam logic [7:0] ADDR_IMASK  = 8'h2c;
  localparam logic [7:0] ADDR_QUEUE  = 8'h40;
  localparam logic [7:0] ADDR_QEND   = 8'h5c;

  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [5:0]  ISTAT_RESET = 6'h00;

  // interrupt status bit positions
  localparam int unsigned INT_STEP_BIT = 4;
  localparam int unsigned INT_WDOG_BIT = 5;
  localparam int unsigned INT_BITS     = 6;

  // step opcodes, upper nibble of a step
  localparam logic [3:0] OP_NOP      = 4'h0;
  localparam logic [3:0] OP_WAIT_IN  = 4'h1;
  localparam logic [3:0] OP_EMIT_LO  = 4'h2;
  localparam logic [3:0] OP_EMIT_HI  = 4'h3;
  localparam logic [3:0] OP_WAIT_TMR = 4'h4;
  localparam logic [3:0] OP_IRQ      = 4'h5;
  localparam logic [3:0] OP_JUMP     = 4'h6;
  localparam logic [3:0] OP_JUMP_CTR = 4'h7;
  localparam logic [3:0] OP_COPY     = 4'h8;
  localparam logic [3:0] OP_CTR_INC  = 4'h9;

  // copy targets
  localparam logic [2:0] COPY_TLIM0 = 3'h0;
  localparam logic [2:0] COPY_TLIM1 = 3'h1;
  localparam logic [2:0] COPY_CLIM0 = 3'h2;
  localparam logic [2:0] COPY_CLIM1 = 3'h3;
  localparam logic [2:0] COPY_SDLIM = 3'h4;
  localparam logic [2:0] COPY_LIT   = 3'h5;

  typedef struct packed {
    logic single_step;
    logic edge_falling;
    logic start;
    logic enable;
  } ctrl_type;

  typedef struct packed {
    logic [3:0] op;
    logic [3:0] arg;
  } step_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_DELAY = 3'b100
  } state_type;

endpackage

//--- src/trigger_sequencer.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module trigger_sequencer (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire logic                                    clk_en,
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [7:0]                              paddr,
  input  wire logic [31:0]                             pwdata,
  output logic      [31:0]                             prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  input  wire logic [trigger_seq_pkg::IN_COUNT-1:0]    trig_in,
  output logic      [trigger_seq_pkg::OUT_COUNT-1:0]   trig_out,
  output logic                                         sequencer_output_18,
  output logic                                         sequencer_output_19,
  output logic      [trigger_seq_pkg::INT_COUNT-1:0]   step_irq,
  output logic                                         irq
);

  trigger_seq_pkg::ctrl_type  ctrl;
  trigger_seq_pkg::state_type state;
  trigger_seq_pkg::step_type  step;
  logic [7:0]  step_queue_regs [trigger_seq_pkg::QUEUE_LEN];
  logic [2:0]  ptr;
  logic [15:0] timer_limit [2];
  logic [15:0] counter_limit [2];
  logic [15:0] step_delay_limit;
  logic [15:0] literal_value;
  logic [15:0] general_hold_value;
  logic [15:0] wdog_limit;
  logic [15:0] timer_count [2];
  logic [15:0] counter_count [2];
  logic [15:0] delay_count;
  logic [15:0] wdog_count;
  logic [trigger_seq_pkg::INT_BITS-1:0] int_status;
  logic [trigger_seq_pkg::INT_BITS-1:0] int_mask;
  logic [trigger_seq_pkg::INT_BITS-1:0] int_event;
  logic [trigger_seq_pkg::IN_COUNT-1:0] trig_prev;
  logic [trigger_seq_pkg::IN_COUNT-1:0] trig_edge;
  logic        wr_en;
  logic        setup;
  logic        step_done;
  logic        step_fire;
  logic        waiting;
  logic        wdog_fire;
  logic [2:0]  next_ptr;
  logic [31:0] next_rdata;
  logic        next_err;

  function automatic logic [15:0] low16(input logic [31:0] d);
    return d[15:0];
  endfunction

  function automatic logic in_queue(input logic [7:0] a);
    return (a >= trigger_seq_pkg::ADDR_QUEUE) && (a <= trigger_seq_pkg::ADDR_QEND)
           && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] queue_index(input logic [7:0] a);
    logic [7:0] off;
    off = a - trigger_seq_pkg::ADDR_QUEUE;
    return off[4:2];
  endfunction

  assign setup = psel && !penable;
  assign wr_en = clk_en && psel && penable && pready && pwrite;
  assign step  = trigger_seq_pkg::step_type'(step_queue_regs[ptr]);

  // one edge pick for all inputs, set by ctrl.edge_falling
  assign trig_edge = ctrl.edge_falling ? (trig_prev & ~trig_in)
                                       : (trig_in & ~trig_prev);

  // step evaluation
  always_comb begin
    step_done = 1'b0;
    waiting   = 1'b0;
    next_ptr  = ptr + 3'h1;
    unique case (step.op)
      trigger_seq_pkg::OP_WAIT_IN: begin
        step_done = trig_edge[step.arg];
        waiting   = !step_done;
      end
      trigger_seq_pkg::OP_WAIT_TMR: begin
        step_done = timer_count[step.arg[0]] >= timer_limit[step.arg[0]];
        waiting   = !step_done;
      end
      trigger_seq_pkg::OP_JUMP: begin
        step_done = 1'b1;
        next_ptr  = step.arg[2:0];
      end
      trigger_seq_pkg::OP_JUMP_CTR: begin
        step_done = 1'b1;
        if (counter_count[step.arg[3]] < counter_limit[step.arg[3]]) begin
          next_ptr = step.arg[2:0];
        end
      end
      default: begin
        step_done = 1'b1;
      end
    endcase
  end

  assign wdog_fire = (state == trigger_seq_pkg::ST_EXEC) && waiting
                     && (wdog_limit != trigger_seq_pkg::LIMIT_RESET)
                     && (wdog_count >= wdog_limit);

  // no step side effects once the sequence is stopped
  assign step_fire = (state == trigger_seq_pkg::ST_EXEC) && step_done
                     && ctrl.enable && ctrl.start;

  always_comb begin
    int_event = '0;
    if (step_fire) begin
      if (step.op == trigger_seq_pkg::OP_IRQ) begin
        int_event[step.arg[1:0]] = 1'b1;
      end
      int_event[trigger_seq_pkg::INT_STEP_BIT] = ctrl.single_step;
    end
    int_event[trigger_seq_pkg::INT_WDOG_BIT] = wdog_fire;
  end

  // control and sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl  <= '0;
      state <= trigger_seq_pkg::ST_IDLE;
      ptr   <= 3'h0;
    end else if (clk_en) begin
      if (wr_en && paddr == trigger_seq_pkg::ADDR_CTRL) begin
        ctrl <= trigger_seq_pkg::ctrl_type'(pwdata[3:0]);
      end
      unique case (state)
        trigger_seq_pkg::ST_IDLE: begin
          if (ctrl.enable && ctrl.start) begin
            state <= trigger_seq_pkg::ST_EXEC;
          end
        end
        trigger_seq_pkg::ST_EXEC: begin
          if (wdog_fire) begin
            ctrl.start <= 1'b0;
            state      <= trigger_seq_pkg::ST_IDLE;
          end else if (!(ctrl.enable && ctrl.start)) begin
            state <= trigger_seq_pkg::ST_IDLE;
          end else if (step_done) begin
            ptr <= next_ptr;
            if (step_delay_limit != trigger_seq_pkg::LIMIT_RESET) begin
              state <= trigger_seq_pkg::ST_DELAY;
            end
          end
        end
        trigger_seq_pkg::ST_DELAY: begin
          if (!(ctrl.enable && ctrl.start)) begin
            state <= trigger_seq_pkg::ST_IDLE;
          end else if (delay_count >= step_delay_limit) begin
            state <= trigger_seq_pkg::ST_EXEC;
          end
        end
      endcase
      if (!ctrl.enable) begin
        ptr <= 3'h0;
      end
    end
  end

  // queue, limits, hold and literal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < trigger_seq_pkg::QUEUE_LEN; i++) begin
        step_queue_regs[i] <= 8'h00;
      end
      timer_limit        <= '{default: trigger_seq_pkg::LIMIT_RESET};
      counter_limit      <= '{default: trigger_seq_pkg::LIMIT_RESET};
      step_delay_limit   <= trigger_seq_pkg::LIMIT_RESET;
      literal_value      <= trigger_seq_pkg::LIMIT_RESET;
      general_hold_value <= trigger_seq_pkg::LIMIT_RESET;
      wdog_limit         <= trigger_seq_pkg::LIMIT_RESET;
    end else if (clk_en) begin
      if (wr_en) begin
        if (in_queue(paddr)) begin
          step_queue_regs[queue_index(paddr)] <= pwdata[7:0];
        end
        unique case (paddr)
          trigger_seq_pkg::ADDR_TLIM0: timer_limit[0]     <= low16(pwdata);
          trigger_seq_pkg::ADDR_TLIM1: timer_limit[1]     <= low16(pwdata);
          trigger_seq_pkg::ADDR_CLIM0: counter_limit[0]   <= low16(pwdata);
          trigger_seq_pkg::ADDR_CLIM1: counter_limit[1]   <= low16(pwdata);
          trigger_seq_pkg::ADDR_SDLIM: step_delay_limit   <= low16(pwdata);
          trigger_seq_pkg::ADDR_LIT:   literal_value      <= low16(pwdata);
          trigger_seq_pkg::ADDR_WDLIM: wdog_limit         <= low16(pwdata);
          trigger_seq_pkg::ADDR_HOLD: begin
            if (!(ctrl.enable && ctrl.start)) begin
              general_hold_value <= low16(pwdata);
            end
          end
          default: begin
          end
        endcase
      end
      if (step_fire && step.op == trigger_seq_pkg::OP_COPY) begin
        unique case (step.arg[2:0])
          trigger_seq_pkg::COPY_TLIM0: timer_limit[0]   <= general_hold_value;
          trigger_seq_pkg::COPY_TLIM1: timer_limit[1]   <= general_hold_value;
          trigger_seq_pkg::COPY_CLIM0: counter_limit[0] <= general_hold_value;
          trigger_seq_pkg::COPY_CLIM1: counter_limit[1] <= general_hold_value;
          trigger_seq_pkg::COPY_SDLIM: step_delay_limit <= general_hold_value;
          trigger_seq_pkg::COPY_LIT:   literal_value    <= general_hold_value;
          default: begin
          end
        endcase
      end
    end
  end

  // timers, counters, step delay, watchdog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count   <= '{default: trigger_seq_pkg::LIMIT_RESET};
      counter_count <= '{default: trigger_seq_pkg::LIMIT_RESET};
      delay_count   <= trigger_seq_pkg::LIMIT_RESET;
      wdog_count    <= trigger_seq_pkg::LIMIT_RESET;
      trig_prev     <= '0;
    end else if (clk_en) begin
      trig_prev <= trig_in;
      for (int t = 0; t < 2; t++) begin
        if (state == trigger_seq_pkg::ST_EXEC && step.op == trigger_seq_pkg::OP_WAIT_TMR
            && step.arg[0] == t[0] && !step_done) begin
          timer_count[t] <= timer_count[t] + 16'h0001;
        end else begin
          timer_count[t] <= trigger_seq_pkg::LIMIT_RESET;
        end
      end
      if (step_fire) begin
        if (step.op == trigger_seq_pkg::OP_JUMP_CTR) begin
          if (counter_count[step.arg[3]] < counter_limit[step.arg[3]]) begin
            counter_count[step.arg[3]] <= counter_count[step.arg[3]] + 16'h0001;
          end else begin
            counter_count[step.arg[3]] <= trigger_seq_pkg::LIMIT_RESET;
          end
        end else if (step.op == trigger_seq_pkg::OP_CTR_INC) begin
          if (counter_count[step.arg[0]] >= counter_limit[step.arg[0]]) begin
            counter_count[step.arg[0]] <= trigger_seq_pkg::LIMIT_RESET;
          end else begin
            counter_count[step.arg[0]] <= counter_count[step.arg[0]] + 16'h0001;
          end
        end
      end
      if (state == trigger_seq_pkg::ST_DELAY) begin
        delay_count <= delay_count + 16'h0001;
      end else begin
        delay_count <= 16'h0001;
      end
      if (state == trigger_seq_pkg::ST_EXEC && waiting) begin
        wdog_count <= wdog_count + 16'h0001;
      end else begin
        wdog_count <= trigger_seq_pkg::LIMIT_RESET;
      end
    end
  end

  // trigger outputs and interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_out            <= '0;
      sequencer_output_18 <= 1'b0;
      sequencer_output_19 <= 1'b0;
      int_status          <= trigger_seq_pkg::ISTAT_RESET;
      int_mask            <= trigger_seq_pkg::ISTAT_RESET;
      step_irq            <= '0;
      irq                 <= 1'b0;
    end else if (clk_en) begin
      trig_out            <= '0;
      sequencer_output_18 <= 1'b0;
      sequencer_output_19 <= 1'b0;
      if (step_fire) begin
        if (step.op == trigger_seq_pkg::OP_EMIT_LO) begin
          trig_out[{1'b0, step.arg}] <= 1'b1;
        end
        if (step.op == trigger_seq_pkg::OP_EMIT_HI) begin
          trig_out[{1'b1, step.arg}] <= 1'b1;
          sequencer_output_18 <= (step.arg == 4'h2);
          sequencer_output_19 <= (step.arg == 4'h3);
        end
      end
      if (wr_en && paddr == trigger_seq_pkg::ADDR_IMASK) begin
        int_mask <= pwdata[trigger_seq_pkg::INT_BITS-1:0];
      end
      if (wr_en && paddr == trigger_seq_pkg::ADDR_ISTAT) begin
        int_status <= (int_status & ~pwdata[trigger_seq_pkg::INT_BITS-1:0]) | int_event;
      end else begin
        int_status <= int_status | int_event;
      end
      step_irq <= int_status[trigger_seq_pkg::INT_COUNT-1:0]
                  & int_mask[trigger_seq_pkg::INT_COUNT-1:0];
      irq      <= |(int_status & int_mask);
    end
  end

  // apb read data and handshake
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (in_queue(paddr)) begin
      next_rdata = {24'h00_0000, step_queue_regs[queue_index(paddr)]};
    end else begin
      unique case (paddr)
        trigger_seq_pkg::ADDR_CTRL:   next_rdata = {28'h000_0000, ctrl};
        trigger_seq_pkg::ADDR_STATUS: next_rdata = {16'h0000, 5'h00, state, 5'h00, ptr};
        trigger_seq_pkg::ADDR_TLIM0:  next_rdata = {16'h0000, timer_limit[0]};
        trigger_seq_pkg::ADDR_TLIM1:  next_rdata = {16'h0000, timer_limit[1]};
        trigger_seq_pkg::ADDR_CLIM0:  next_rdata = {16'h0000, counter_limit[0]};
        trigger_seq_pkg::ADDR_CLIM1:  next_rdata = {16'h0000, counter_limit[1]};
        trigger_seq_pkg::ADDR_SDLIM:  next_rdata = {16'h0000, step_delay_limit};
        trigger_seq_pkg::ADDR_LIT:    next_rdata = {16'h0000, literal_value};
        trigger_seq_pkg::ADDR_HOLD:   next_rdata = {16'h0000, general_hold_value};
        trigger_seq_pkg::ADDR_WDLIM:  next_rdata = {16'h0000, wdog_limit};
        trigger_seq_pkg::ADDR_ISTAT:  next_rdata = {26'h000_0000, int_status};
        trigger_seq_pkg::ADDR_IMASK:  next_rdata = {26'h000_0000, int_mask};
        default:                      next_err   = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && next_err;
      if (setup && !pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

endmodule // trigger_sequencer

//--- sim/trigger_sequencer_asserts.sv
`timescale 1ns/1ps
module trigger_sequencer_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] trig_in,
  input wire logic [31:0] trig_out,
  input wire logic        sequencer_output_18,
  input wire logic        sequencer_output_19,
  input wire logic [3:0]  step_irq,
  input wire logic        irq
);
  logic       run_sw;
  logic [3:0] mask_q;
  logic       wr_ok;
  logic       unm;
  assign wr_ok = psel && penable && pready && pwrite && clk_en;
  assign unm   = paddr[1:0] == 2'h0 && (paddr > 8'h5c || (paddr > 8'h2c && paddr < 8'h40));
  // software view of enable and start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_sw <= 1'b0;
    else if (wr_ok && paddr == trigger_seq_pkg::ADDR_CTRL) run_sw <= &pwdata[1:0];
  end
  // software view of the mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mask_q <= 4'h0;
    else if (wr_ok && paddr == trigger_seq_pkg::ADDR_IMASK) mask_q <= pwdata[3:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY_AFTER_SETUP: assert property (psel && !penable && clk_en ##1 clk_en |-> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready && clk_en |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED_ERR: assert property (psel && !penable && !pwrite && unm ##1 pready |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  AST_OUT18_COPY: assert property (sequencer_output_18 == trig_out[18])
    else $error("output 18 differs");
  AST_OUT19_COPY: assert property (sequencer_output_19 == trig_out[19])
    else $error("output 19 differs");
  AST_IDLE_SILENT: assert property (!run_sw [*2] |-> trig_out == 32'h0)
    else $error("trigger while stopped");
  AST_STEP_IRQ_MASK: assert property ((step_irq & ~(mask_q | $past(mask_q))) == 4'h0)
    else $error("masked step interrupt seen");
  AST_IRQ_FOLLOWS: assert property (|step_irq |-> irq)
    else $error("irq low with step interrupt");
  cover property (trig_out[18]);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule // trigger_sequencer_asserts

bind trigger_sequencer trigger_sequencer_asserts i_asserts (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .trig_in(trig_in), .trig_out(trig_out),
  .sequencer_output_18(sequencer_output_18), .sequencer_output_19(sequencer_output_19),
  .step_irq(step_irq), .irq(irq));

//--- sim/peripheral_model.sv
`timescale 1ns/1ps
module peripheral_model (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [31:0] trig_out,
  input wire logic [7:0]  lag,
  output logic     [15:0] trig_in
);
  logic [7:0] due [16];
  // each triggered unit on trig_out 0 to 15 answers by toggling its trig_in line after lag cycles; 16 to 31 get no answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_in <= 16'h0000;
      for (int n = 0; n < 16; n++) due[n] <= 8'h00;
    end else begin
      for (int n = 0; n < 16; n++) begin
        if (trig_out[n]) due[n] <= lag;
        else if (due[n] != 8'h00) begin
          due[n] <= due[n] - 8'h01;
          if (due[n] == 8'h01) trig_in[n] <= ~trig_in[n];
        end
      end
    end
  end
endmodule // peripheral_model

//--- sim/peripheral_trigger_sequencer_tb.sv
`timescale 1ns/1ps
module peripheral_trigger_sequencer_tb;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic        irq, out18, out19, err;
  logic [7:0]  paddr, lag;
  logic [31:0] pwdata, prdata, rd, trig_out;
  logic [15:0] trig_in;
  logic [3:0]  step_irq;
  int          n_mismatch, checks_done, cyc, t0, t18;
  int          cnt [32];

  trigger_sequencer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in), .trig_out(trig_out),
    .sequencer_output_18(out18), .sequencer_output_19(out19), .step_irq(step_irq),
    .irq(irq));
  peripheral_model i_peer (.pclk(pclk), .presetn(presetn), .trig_out(trig_out), .lag(lag),
    .trig_in(trig_in));

  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    for (int n = 0; n < 32; n++) if (trig_out[n] === 1'b1) cnt[n] <= cnt[n] + 1;
    if (trig_out[18] === 1'b1) t18 <= cyc;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task prog(input logic [63:0] q);
    for (int i = 0; i < 8; i++) wr(trigger_seq_pkg::ADDR_QUEUE + 8'(4 * i), {24'h0, q[8*i+:8]});
  endtask
  task run(input logic [31:0] c);
    int k;
    wr(trigger_seq_pkg::ADDR_CTRL, 32'h0);
    wr(trigger_seq_pkg::ADDR_CTRL, c);
    t0 = cyc;
    k = 0;
    do begin apb(1'b0, trigger_seq_pkg::ADDR_STATUS, 32'h0); k++; end
      while (rd[10:8] !== 3'b001 && k < 80);
    check(rd & 32'h700, 32'h100);
  endtask

  initial begin
    pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0; lag = 8'h04; n_mismatch = 0; checks_done = 0;
    cyc = 0; t0 = 0; t18 = 0;
    foreach (cnt[n]) cnt[n] = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(trigger_seq_pkg::ADDR_HOLD, 32'h0);
    rdchk(trigger_seq_pkg::ADDR_CLIM1, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(trigger_seq_pkg::ADDR_CLIM1, 32'ha5c3);
    rdchk(trigger_seq_pkg::ADDR_CLIM1, 32'ha5c3);
    $display("registers done");
    wr(trigger_seq_pkg::ADDR_WDLIM, 32'h32);
    wr(trigger_seq_pkg::ADDR_HOLD, 32'h1234);
    wr(trigger_seq_pkg::ADDR_CTRL, 32'h3);
    wr(trigger_seq_pkg::ADDR_HOLD, 32'hbeef);
    rdchk(trigger_seq_pkg::ADDR_HOLD, 32'h1234);
    wr(trigger_seq_pkg::ADDR_CTRL, 32'h0);
    prog(64'h0000_6085_5233_1525);
    run(32'h3);
    rdchk(trigger_seq_pkg::ADDR_LIT, 32'h1234);
    check(cnt[5], 32'd2);
    check(cnt[19], 32'd1);
    rdchk(trigger_seq_pkg::ADDR_ISTAT, 32'h24);
    check({31'h0, irq}, 32'h0);
    wr(trigger_seq_pkg::ADDR_IMASK, 32'h4);
    repeat (2) @(negedge pclk);
    check({28'h0, step_irq}, 32'h4);
    check({31'h0, irq}, 32'h1);
    wr(trigger_seq_pkg::ADDR_ISTAT, 32'h3f);
    rdchk(trigger_seq_pkg::ADDR_ISTAT, 32'h0);
    $display("sequence and interrupts done");
    lag <= 8'd20;
    run(32'h7);
    check(cnt[19], 32'd1);
    run(32'h7);
    check(cnt[19], 32'd2);
    $display("falling edge done");
    wr(trigger_seq_pkg::ADDR_CLIM1, 32'h3);
    prog(64'h0000_0000_1f31_7820);
    run(32'h3);
    check(cnt[0], 32'd4);
    check(cnt[17], 32'd1);
    $display("counter jump done");
    wr(trigger_seq_pkg::ADDR_HOLD, 32'd30);
    prog(64'h0000_0000_1f32_4080);
    run(32'hb);
    check(32'((t18 - t0) >= 30 && (t18 - t0) <= 40), 32'h1);
    check(cnt[18], 32'd1);
    rdchk(trigger_seq_pkg::ADDR_TLIM0, 32'd30);
    apb(1'b0, trigger_seq_pkg::ADDR_ISTAT, 32'h0);
    check(rd & 32'h10, 32'h10);
    $display("timer and single step done");
    conclude;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude;
  end
endmodule // peripheral_trigger_sequencer_tb
